// ### logic/capture_compare_pwm_control.sv
// register top: axi4-lite slave, five channels and timer selection
// assumes timers live outside and follow the reset requests given here
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "chan_params.svh"

// Operation
// - mode zero turns the channel off and clears its internal state.
// - mode 0010 toggles the output pin on every compare match.
// - modes 0100-0111 capture on falling, rising, fourth and sixteenth edges.
// - mode 1000 sets the pin high on match and raises the flag.
// - mode 1001 drives the pin low on match and raises the flag.
// - mode 1010 raises only the flag on match, pin unchanged.
// - mode 1011 raises flag, keeps pin, resets the selected timer.
// - channel five's special event also sets the converter-on control.
// - pwm duty is ten bits: control bits 5-4 low, duty byte high.
// - config in bits 7-6, mode in 3-0; top bits 11 mean pwm.
// - capture or compare uses output a only; b, c, d released.
// - half bridge: config 0x drives a only, 1x drives a and b.
// - full bridge: 00 drives a, 10 drives a and b; c, d released.
// - full bridge 01 forward: d modulated, a active, b and c inactive.
// - full bridge 11 reverse: b modulated, c active, a and d inactive.
// - half bridge polarity: mode bit 1 inverts a, bit 0 inverts b.
// - full bridge polarity: mode bit 1 inverts a, c; bit 0 b, d.
// - timer select 00, 01, 10 pick timer pairs 1/2, 3/4, 5/6.
// - low selection register: channel 3 bits 7-6, 2 bits 4-3, 1 bits 1-0.
// - high selection register: channel 5 bits 3-2, channel 4 bits 1-0.
// - upper four bits of the high selection register read zero.
module capture_compare_pwm_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] cc_time1,
  input wire logic [15:0] cc_time3,
  input wire logic [15:0] cc_time5,
  input wire logic [9:0] pwm_time2,
  input wire logic [9:0] pwm_time4,
  input wire logic [9:0] pwm_time6,
  input wire logic [4:0] output_a_in,
  output logic [4:0] output_a,
  output logic [4:0] output_a_oe_n,
  output logic [4:0] output_b,
  output logic [4:0] output_b_oe_n,
  output logic [4:0] output_c,
  output logic [4:0] output_c_oe_n,
  output logic [4:0] output_d,
  output logic [4:0] output_d_oe_n,
  output logic [2:0] timer_reset,
  output logic converter_on
);
  import chan_types_pkg::*;

  localparam int N = `NUM_CHAN;

  // ****************************************
  // write channel
  // ****************************************
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // the write lands one cycle after both halves are held
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire w_in_chan = (waddr_reg < `CHAN_AREA_END) && (waddr_reg[3:2] != 2'h3);
  wire [2:0] w_chan = waddr_reg[6:4];
  wire [1:0] w_sub = waddr_reg[3:2];
  wire w_flags = do_write && wstrb_reg[0] && (waddr_reg == `OFS_FLAGS);
  wire w_tsel_low = do_write && wstrb_reg[0] &&
                    (waddr_reg == `OFS_TSEL_LOW);
  wire w_tsel_high = do_write && wstrb_reg[0] &&
                     (waddr_reg == `OFS_TSEL_HIGH);
  wire w_mapped = w_in_chan || (waddr_reg == `OFS_FLAGS) ||
                  (waddr_reg == `OFS_TSEL_LOW) ||
                  (waddr_reg == `OFS_TSEL_HIGH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        waddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_mapped ? 2'h0 : 2'h2;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // shared registers
  // ****************************************
  logic [7:0] tsel_low_reg;
  logic [3:0] tsel_high_reg;
  logic [4:0] flag_reg;
  logic [4:0] match_p, capture_p, special_p;
  logic [2:0] treset_p [N];
  logic [1:0] tsel [N];

  assign tsel[0] = tsel_low_reg[1:0];
  assign tsel[1] = tsel_low_reg[4:3];
  assign tsel[2] = tsel_low_reg[7:6];
  assign tsel[3] = tsel_high_reg[1:0];
  assign tsel[4] = tsel_high_reg[3:2];

  // a flag set by hardware wins over a clear in the same cycle
  wire [4:0] flag_clr = w_flags ? wdata_reg[4:0] : 5'h00;
  wire [4:0] flag_next = (flag_reg & ~flag_clr) | match_p | capture_p;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel_low_reg <= `TSEL_RESET;
      tsel_high_reg <= 4'h0;
      flag_reg <= 5'h00;
      timer_reset <= 3'h0;
      converter_on <= 1'b0;
    end else begin
      if (w_tsel_low) begin
        tsel_low_reg <= wdata_reg[7:0] & `TSEL_LOW_MASK;
      end
      if (w_tsel_high) begin
        tsel_high_reg <= wdata_reg[3:0] & `TSEL_HIGH_MASK;
      end
      flag_reg <= flag_next;
      timer_reset <= treset_p[0] | treset_p[1] | treset_p[2] |
                     treset_p[3] | treset_p[4];
      converter_on <= special_p[4];
    end
  end

  // ****************************************
  // per-channel registers and cores
  // ****************************************
  logic [7:0] ctrl_reg [N];
  logic [7:0] duty_reg [N];
  logic [15:0] value_reg [N];
  logic [15:0] cap_data [N];

  for (genvar i = 0; i < N; i++) begin : g_chan
    localparam bit FULL = 1'(`FULL_BRIDGE_MASK >> i);
    localparam bit HALF = 1'(`HALF_BRIDGE_MASK >> i);
    localparam logic [7:0] CMASK = (FULL || HALF) ? 8'hff : `STD_CTRL_MASK;
    wire sel = do_write && w_in_chan && (w_chan == 3'(i));
    wire w_ctrl = sel && wstrb_reg[0] && (w_sub == `OFS_CTRL);
    wire w_duty = sel && wstrb_reg[0] && (w_sub == `OFS_DUTY);
    wire w_val_lo = sel && wstrb_reg[0] && (w_sub == `OFS_VALUE);
    wire w_val_hi = sel && wstrb_reg[1] && (w_sub == `OFS_VALUE);
    wire [9:0] duty10 = {duty_reg[i], ctrl_reg[i][`DUTY_LO_HI:`DUTY_LO_LO]};

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_reg[i] <= `CTRL_RESET;
        duty_reg[i] <= `DUTY_RESET;
        value_reg[i] <= `VALUE_RESET;
      end else begin
        if (w_ctrl) begin
          ctrl_reg[i] <= wdata_reg[7:0] & CMASK;
        end
        if (w_duty) begin
          duty_reg[i] <= wdata_reg[7:0];
        end
        // a capture outranks a software write to the same word
        if (capture_p[i]) begin
          value_reg[i] <= cap_data[i];
        end else begin
          if (w_val_lo) begin
            value_reg[i][7:0] <= wdata_reg[7:0];
          end
          if (w_val_hi) begin
            value_reg[i][15:8] <= wdata_reg[15:8];
          end
        end
      end
    end

    chan_core #(
      .FULL_BRIDGE(FULL),
      .HALF_BRIDGE(HALF)
    ) u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode_select(mode_t'(ctrl_reg[i][`MODE_HI:`MODE_LO])),
      .output_configuration(cfg_t'(ctrl_reg[i][`CFG_HI:`CFG_LO])),
      .duty(duty10),
      .timer_select(tsel[i]),
      .cc_time1(cc_time1),
      .cc_time3(cc_time3),
      .cc_time5(cc_time5),
      .pwm_time2(pwm_time2),
      .pwm_time4(pwm_time4),
      .pwm_time6(pwm_time6),
      .compare_value(value_reg[i]),
      .output_a_in(output_a_in[i]),
      .output_a(output_a[i]),
      .output_a_oe_n(output_a_oe_n[i]),
      .output_b(output_b[i]),
      .output_b_oe_n(output_b_oe_n[i]),
      .output_c(output_c[i]),
      .output_c_oe_n(output_c_oe_n[i]),
      .output_d(output_d[i]),
      .output_d_oe_n(output_d_oe_n[i]),
      .capture_pulse(capture_p[i]),
      .capture_data(cap_data[i]),
      .match_pulse(match_p[i]),
      .timer_reset(treset_p[i]),
      .special_pulse(special_p[i])
    );
  end

  // ****************************************
  // read channel
  // ****************************************
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  wire r_in_chan = (raddr < `CHAN_AREA_END) && (raddr[3:2] != 2'h3);
  wire [2:0] r_chan = raddr[6:4];
  wire [15:0] r_chan_val = (raddr[3:2] == `OFS_CTRL) ?
                           {8'h00, ctrl_reg[r_chan]} :
                           (raddr[3:2] == `OFS_DUTY) ?
                           {8'h00, duty_reg[r_chan]} : value_reg[r_chan];
  wire [31:0] r_val = r_in_chan ? {16'h0000, r_chan_val} :
    (raddr == `OFS_FLAGS) ? {27'h0, flag_reg} :
    (raddr == `OFS_TSEL_LOW) ? {24'h0, tsel_low_reg} :
    (raddr == `OFS_TSEL_HIGH) ? {28'h0, tsel_high_reg} : 32'h0;
  wire r_mapped = r_in_chan || (raddr == `OFS_FLAGS) ||
                  (raddr == `OFS_TSEL_LOW) || (raddr == `OFS_TSEL_HIGH);

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= r_val;
      rresp_reg <= r_mapped ? 2'h0 : 2'h2;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### logic/chan_core.sv
// one capture / compare / pwm channel with its output steering
// assumes timer counts come from the same clock; pin a input is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "chan_params.svh"

module chan_core #(
  parameter bit FULL_BRIDGE = 1'b0,
  parameter bit HALF_BRIDGE = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire chan_types_pkg::mode_t mode_select,
  input wire chan_types_pkg::cfg_t output_configuration,
  input wire logic [9:0] duty,
  input wire logic [1:0] timer_select,
  input wire logic [15:0] cc_time1,
  input wire logic [15:0] cc_time3,
  input wire logic [15:0] cc_time5,
  input wire logic [9:0] pwm_time2,
  input wire logic [9:0] pwm_time4,
  input wire logic [9:0] pwm_time6,
  input wire logic [15:0] compare_value,
  input wire logic output_a_in,
  output logic output_a,
  output logic output_a_oe_n,
  output logic output_b,
  output logic output_b_oe_n,
  output logic output_c,
  output logic output_c_oe_n,
  output logic output_d,
  output logic output_d_oe_n,
  output logic capture_pulse,
  output logic [15:0] capture_data,
  output logic match_pulse,
  output logic [2:0] timer_reset,
  output logic special_pulse
);
  import chan_types_pkg::*;

  // ****************************************
  // mode decode
  // ****************************************
  wire tsel_ok = (timer_select != `TSEL_RESERVED);
  wire is_off = (mode_select == MODE_OFF) || (mode_select == MODE_RSV1) ||
                (mode_select == MODE_RSV3) || !tsel_ok;
  wire is_pwm = (mode_select[3:2] == 2'b11) && !is_off;
  wire is_cap = (mode_select[3:2] == 2'b01) && !is_off;
  wire is_cmp = !is_off && !is_pwm && !is_cap;
  wire [15:0] cc_time = (timer_select == 2'b00) ? cc_time1 :
                        (timer_select == 2'b01) ? cc_time3 : cc_time5;
  wire [9:0] pwm_time = (timer_select == 2'b00) ? pwm_time2 :
                        (timer_select == 2'b01) ? pwm_time4 : pwm_time6;

  // ****************************************
  // capture edge and prescale
  // ****************************************
  logic sync1_reg, sync2_reg, prev_reg;
  logic [3:0] presc_reg;
  logic eq_reg, latch_reg;
  logic [3:0] presc_limit;
  wire rise = sync2_reg && !prev_reg;
  wire fall = !sync2_reg && prev_reg;
  wire cap_edge = is_cap && ((mode_select == MODE_CAP_FALL) ? fall : rise);
  assign presc_limit = (mode_select == MODE_CAP_RISE4) ? 4'h3 :
                       (mode_select == MODE_CAP_RISE16) ? 4'hf : 4'h0;
  wire cap_fire = cap_edge && (presc_reg == presc_limit);

  // ****************************************
  // compare match
  // ****************************************
  // match fires once per arrival at the value, not for every idle cycle
  wire cmp_eq = is_cmp && (cc_time == compare_value);
  wire cmp_fire = cmp_eq && !eq_reg;
  wire latch_next = !is_cmp ? 1'b0 :
    (cmp_fire && mode_select == MODE_TOGGLE) ? !latch_reg :
    (cmp_fire && mode_select == MODE_CMP_SET) ? 1'b1 :
    (cmp_fire && mode_select == MODE_CMP_CLEAR) ? 1'b0 :
    latch_reg;
  wire flag_fire = cmp_fire && mode_select[3];
  wire event_fire = cmp_fire && (mode_select == MODE_CMP_EVENT);

  // ****************************************
  // pwm level and polarity
  // ****************************************
  wire pwm_level = (pwm_time < duty);
  wire pol_ac = mode_select[1];
  wire pol_bd = mode_select[0];

  logic [3:0] out_next;
  logic [3:0] oe_n_next;
  always_comb begin
    out_next = 4'h0;
    oe_n_next = 4'hf;
    if (is_cmp) begin
      out_next[0] = latch_next;
      oe_n_next[0] = 1'b0;
    end else if (is_pwm) begin
      oe_n_next[0] = 1'b0;
      if (FULL_BRIDGE) begin
        unique case (output_configuration)
          CFG_SINGLE: begin
            out_next[0] = pwm_level ^ pol_ac;
          end
          CFG_HALF: begin
            out_next[0] = pwm_level ^ pol_ac;
            out_next[1] = !pwm_level ^ pol_bd;
            oe_n_next[1] = 1'b0;
          end
          CFG_FORWARD: begin
            out_next = {pwm_level ^ pol_bd, pol_ac, pol_bd,
                        !pol_ac};
            oe_n_next = 4'h0;
          end
          CFG_REVERSE: begin
            out_next = {pol_bd, !pol_ac, pwm_level ^ pol_bd,
                        pol_ac};
            oe_n_next = 4'h0;
          end
        endcase
      end else if (HALF_BRIDGE) begin
        out_next[0] = pwm_level ^ pol_ac;
        if (output_configuration[1]) begin
          // b is the inverted pwm level under its own polarity bit, with no dead-band delay
          out_next[1] = !pwm_level ^ pol_bd;
          oe_n_next[1] = 1'b0;
        end
      end else begin
        out_next[0] = pwm_level;
      end
    end
  end

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= output_a_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || is_off) begin
      presc_reg <= 4'h0;
      eq_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      if (!is_cap || cap_fire) begin
        presc_reg <= 4'h0;
      end else if (cap_edge) begin
        presc_reg <= presc_reg + 4'h1;
      end
      eq_reg <= cmp_eq;
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
      output_c <= 1'b0;
      output_d <= 1'b0;
      output_a_oe_n <= 1'b1;
      output_b_oe_n <= 1'b1;
      output_c_oe_n <= 1'b1;
      output_d_oe_n <= 1'b1;
      capture_pulse <= 1'b0;
      capture_data <= 16'h0000;
      match_pulse <= 1'b0;
      timer_reset <= 3'h0;
      special_pulse <= 1'b0;
    end else begin
      {output_d, output_c, output_b, output_a} <= out_next;
      {output_d_oe_n, output_c_oe_n, output_b_oe_n, output_a_oe_n} <=
        oe_n_next;
      capture_pulse <= cap_fire;
      if (cap_fire) begin
        capture_data <= cc_time;
      end
      match_pulse <= flag_fire;
      timer_reset <= {event_fire && timer_select == 2'b10,
                      event_fire && timer_select == 2'b01,
                      event_fire && timer_select == 2'b00};
      special_pulse <= event_fire;
    end
  end

endmodule
`default_nettype wire

// ### logic/chan_params.svh
// offsets, field positions, reset values and counts for the channel block
// assumes a byte-addressed 32-bit register bus with one register per word
`ifndef CHAN_PARAMS_SVH
`define CHAN_PARAMS_SVH

// ****************************************
// channel count and register map
// ****************************************
`define NUM_CHAN 5
`define CHAN_STRIDE 8'h10
`define OFS_CTRL 2'h0
`define OFS_DUTY 2'h1
`define OFS_VALUE 2'h2
`define OFS_FLAGS 8'h50
`define OFS_TSEL_LOW 8'h54
`define OFS_TSEL_HIGH 8'h58
`define CHAN_AREA_END 8'h50

// ****************************************
// field positions
// ****************************************
`define CFG_HI 7
`define CFG_LO 6
`define DUTY_LO_HI 5
`define DUTY_LO_LO 4
`define MODE_HI 3
`define MODE_LO 0
`define TSEL_LOW_MASK 8'hdb
`define TSEL_HIGH_MASK 4'hf
`define STD_CTRL_MASK 8'h3f

// ****************************************
// reset values and bridge kinds
// ****************************************
`define CTRL_RESET 8'h00
`define DUTY_RESET 8'h00
`define VALUE_RESET 16'h0000
`define TSEL_RESET 8'h00
`define FULL_BRIDGE_MASK 5'h01
`define HALF_BRIDGE_MASK 5'h06
`define TSEL_RESERVED 2'h3

`endif

// ### logic/chan_types_pkg.sv
// types shared by the channel core and the register top
// assumes chan_params.svh supplies the numeric constants
package chan_types_pkg;

  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_RSV1 = 4'b0001,
    MODE_TOGGLE = 4'b0010,
    MODE_RSV3 = 4'b0011,
    MODE_CAP_FALL = 4'b0100,
    MODE_CAP_RISE = 4'b0101,
    MODE_CAP_RISE4 = 4'b0110,
    MODE_CAP_RISE16 = 4'b0111,
    MODE_CMP_SET = 4'b1000,
    MODE_CMP_CLEAR = 4'b1001,
    MODE_CMP_SOFT = 4'b1010,
    MODE_CMP_EVENT = 4'b1011,
    MODE_PWM_HH = 4'b1100,
    MODE_PWM_HL = 4'b1101,
    MODE_PWM_LH = 4'b1110,
    MODE_PWM_LL = 4'b1111
  } mode_t;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'b00,
    CFG_FORWARD = 2'b01,
    CFG_HALF = 2'b10,
    CFG_REVERSE = 2'b11
  } cfg_t;

endpackage

// ### sim/bridge_partner.sv
// far side: timers 1 to 6 and the wire of each pin a
// assumes the bench drives pin_stim wherever the block releases pin a
`timescale 1ns/1ps
`default_nettype none
module bridge_partner #(
  parameter logic [15:0] PERIOD = 16'h00c8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] timer_reset,
  input wire logic [4:0] output_a,
  input wire logic [4:0] output_a_oe_n,
  input wire logic [4:0] pin_stim,
  output logic [4:0] output_a_in,
  output logic [15:0] cc_time1,
  output logic [15:0] cc_time3,
  output logic [15:0] cc_time5,
  output logic [9:0] pwm_time2,
  output logic [9:0] pwm_time4,
  output logic [9:0] pwm_time6
);
  // ****
  // timers, short period for quick matches
  // ****
  logic [15:0] t_reg [6];
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!aresetn || t_reg[i] == PERIOD - 16'h1 ||
          (i % 2 == 0 && timer_reset[i / 2])) begin
        t_reg[i] <= 16'h0;
      end else begin
        t_reg[i] <= t_reg[i] + 16'h1;
      end
    end
  end
  assign cc_time1 = t_reg[0];
  assign cc_time3 = t_reg[2];
  assign cc_time5 = t_reg[4];
  assign pwm_time2 = t_reg[1][9:0];
  assign pwm_time4 = t_reg[3][9:0];
  assign pwm_time6 = t_reg[5][9:0];
  assign output_a_in = (output_a & ~output_a_oe_n) |
                       (pin_stim & output_a_oe_n);
endmodule
`default_nettype wire

// ### sim/chan_checker_assertions.sv
// checker on the ports of the channel block top
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module chan_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [4:0] output_a_oe_n,
  input wire logic [4:0] output_b_oe_n,
  input wire logic [4:0] output_c_oe_n,
  input wire logic [4:0] output_d_oe_n,
  input wire logic [2:0] timer_reset,
  input wire logic converter_on
);
  // ****
  // properties
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_at(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  tsel_low_a: assert property (
    rd_at(8'h54) |=> (s_axi_rdata & ~32'hdb) == 32'h0)
    else $error("low select pad set");
  tsel_high_a: assert property (
    rd_at(8'h58) |=> s_axi_rdata[31:4] == 28'h0)
    else $error("high select pad set");
  conv_reset_a: assert property (
    converter_on |-> timer_reset != 3'h0)
    else $error("converter without timer reset");
  conv_pulse_a: assert property (
    converter_on |=> !converter_on [*3])
    else $error("converter not a pulse");
  reset_off_a: assert property (
    $rose(aresetn) |-> &output_a_oe_n && &output_b_oe_n && !converter_on)
    else $error("outputs driven after reset");
  half_cd_a: assert property (
    output_c_oe_n[4:1] == 4'hf && output_d_oe_n[4:1] == 4'hf)
    else $error("c or d driven without bridge");
  std_b_a: assert property (
    output_b_oe_n[4:3] == 2'h3)
    else $error("b driven on a standard channel");
  bridge_all_a: assert property (
    !output_c_oe_n[0] |-> !output_a_oe_n[0] && !output_b_oe_n[0] &&
      !output_d_oe_n[0])
    else $error("bridge pin released");
endmodule
bind capture_compare_pwm_control chan_checker i_chk (.*);
`default_nettype wire

// ### sim/testbench.sv
// bench for the channel block with its far-side timer and pin model
// assumes timers wrap every P cycles and pin a of channel 3 is stimulated
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] P = 16'h00c8;
  logic aclk, aresetn, awv, wv, arv, awr, wrd, bv, arr, rv, conv;
  logic [7:0] aw, ar;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr, rs, ws;
  logic [15:0] c1, c3, c5;
  logic [9:0] p2, p4, p6;
  logic [4:0] ain, stim, oa, ob, oc, od, na, nb, nc, nd;
  logic [2:0] trst;
  int errors = 0;
  int checks = 0;
  capture_compare_pwm_control i_dut (.aclk, .aresetn, .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .cc_time1(c1), .cc_time3(c3), .cc_time5(c5),
    .pwm_time2(p2), .pwm_time4(p4), .pwm_time6(p6), .output_a_in(ain),
    .output_a(oa), .output_a_oe_n(na), .output_b(ob), .output_b_oe_n(nb),
    .output_c(oc), .output_c_oe_n(nc), .output_d(od), .output_d_oe_n(nd),
    .timer_reset(trst), .converter_on(conv));
  bridge_partner #(.PERIOD(P)) i_far (.aclk, .aresetn, .timer_reset(trst),
    .output_a(oa), .output_a_oe_n(na), .pin_stim(stim), .output_a_in(ain),
    .cc_time1(c1), .cc_time3(c3), .cc_time5(c5), .pwm_time2(p2),
    .pwm_time4(p4), .pwm_time6(p6));
  // ****
  // bus and compare tasks
  // ****
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n == 400) begin
      errors++;
      results();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    int n = 0;
    aw <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      step(n);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    ws = br;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    int n = 0;
    ar <= a;
    arv <= 1'b1;
    do begin
      step(n);
      if (arr) arv <= 1'b0;
      d = rdat;
      rs = rr;
    end while (!rv);
  endtask
  task automatic wait_a(int c, logic v);
    int n = 0;
    while (!(oa[c] === v && na[c] === 1'b0)) step(n);
    chk("pin a", 32'(v), 32'(oa[c]));
  endtask
  task automatic flag(int c, logic v);
    logic [31:0] d;
    rd(8'h50, d);
    chk("flag", 32'(v), 32'(d[c]));
    wr(8'h50, 8'h1f);
  endtask
  task automatic pin(input logic v);
    stim[2] <= v;
    repeat (8) @(posedge aclk);
  endtask
  // driven-high cycles per pin over one period
  task automatic pwm(int c, logic [7:0] m, logic [31:0] e, logic [3:0] eo);
    logic [31:0] k = 32'h0;
    logic [3:0] o;
    wr(8'(c * 16), m);
    repeat (4) @(posedge aclk);
    repeat (P) begin
      @(posedge aclk);
      o = {nd[c], nc[c], nb[c], na[c]};
      k += {8'(od[c] & ~o[3]), 8'(oc[c] & ~o[2]), 8'(ob[c] & ~o[1]),
            8'(oa[c] & ~o[0])};
    end
    chk("pwm counts", e, k);
    chk("pwm enables", 32'(eo), 32'(o));
  endtask
  // ****
  // scenarios
  // ****
  task automatic s_regs();
    logic [31:0] d;
    wr(8'h54, 8'hff);
    rd(8'h54, d);
    chk("low select", 32'hdb, d);
    wr(8'h58, 8'hff);
    rd(8'h58, d);
    chk("high select", 32'hf, d);
    wr(8'h40, 8'hc5);
    rd(8'h40, d);
    chk("std control", 32'h5, d);
    rd(8'h60, d);
    chk("unmapped resp", 32'h2, 32'(rs));
    wr(8'h60, 8'h00);
    chk("unmapped bresp", 32'h2, 32'(ws));
    wr(8'h40, 8'h00);
    wr(8'h54, 8'h00);
    wr(8'h58, 8'h00);
  endtask
  task automatic s_compare();
    logic [31:0] lows = 32'h0;
    wr(8'h08, 8'h30);
    wr(8'h00, 8'h02);
    wait_a(0, 1'b1);
    wait_a(0, 1'b0);
    wr(8'h50, 8'h1f);
    wr(8'h00, 8'h08);
    wait_a(0, 1'b1);
    flag(0, 1'b1);
    wr(8'h00, 8'h0a);
    repeat (P) begin
      @(posedge aclk);
      lows += {31'h0, ~oa[0]};
    end
    chk("pin kept", 32'h0, lows);
    flag(0, 1'b1);
    wr(8'h00, 8'h09);
    wait_a(0, 1'b0);
    flag(0, 1'b1);
    wr(8'h00, 8'h00);
    repeat (4) @(posedge aclk);
    chk("off released", 32'h1, {31'h0, na[0]});
    wr(8'h54, 8'h03);
    wr(8'h00, 8'h08);
    repeat (2 * P) @(posedge aclk);
    chk("reserved select", 32'h1, {31'h0, na[0]});
    wr(8'h00, 8'h00);
    wr(8'h54, 8'h00);
  endtask
  task automatic s_capture();
    int n;
    for (int i = 0; i < 4; i++) begin
      n = (i < 2) ? 1 : (i == 2 ? 4 : 16);
      wr(8'h20, 8'h00);
      wr(8'h20, 8'h04 + 8'(i));
      wr(8'h50, 8'h1f);
      repeat (n - 1) begin
        pin(1'b1);
        pin(1'b0);
      end
      flag(2, 1'b0);
      pin(1'b1);
      flag(2, i != 0);
      pin(1'b0);
      flag(2, i == 0);
    end
    wr(8'h20, 8'h00);
  endtask
  task automatic s_event();
    logic [2:0] t;
    int n;
    wr(8'h48, 8'h40);
    for (int s = 0; s < 3; s++) begin
      wr(8'h58, {4'h0, 2'(s), 2'h0});
      wr(8'h40, 8'h0b);
      n = 0;
      t = 3'h0;
      while (conv !== 1'b1) begin
        step(n);
        t = trst;
      end
      chk("timer reset", 32'h1 << s, 32'(t));
      chk("pin unchanged", 32'h0, {31'h0, oa[4]});
      flag(4, 1'b1);
      wr(8'h40, 8'h00);
    end
    wr(8'h58, 8'h00);
  endtask
  task automatic s_pwm();
    wr(8'h04, 8'h0c);
    wr(8'h14, 8'h0c);
    pwm(0, 8'h3c, 32'h00000033, 4'he);
    pwm(0, 8'h7c, 32'h330000c8, 4'h0);
    pwm(0, 8'hbc, 32'h00009533, 4'hc);
    pwm(0, 8'hff, 32'hc80095c8, 4'h0);
    pwm(1, 8'h3e, 32'h00000095, 4'he);
    pwm(1, 8'hbd, 32'h00003333, 4'hc);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h00);
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {awv, wv, arv} = 3'h0;
    aw = 8'h0;
    ar = 8'h0;
    wd = 32'h0;
    stim = 5'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_compare();
    s_capture();
    s_event();
    s_pwm();
    results();
  end
endmodule
`default_nettype wire
